// File: pkg/dac_ctrl_pkg.sv
// Constants and types for the quad DAC update and reset control block
package dac_ctrl_pkg;

   // ==================================================================
   // Frame layout
   localparam int          FRAME_BITS   = 24;
   localparam int          CMD_MSB      = 23;
   localparam int          CMD_LSB      = 20;
   localparam int          ADDR_MSB     = 19;
   localparam int          ADDR_LSB     = 16;
   localparam int          DATA_MSB     = 15;
   localparam int          CHANNELS     = 4;
   localparam int          CODE_BITS    = 16;
   localparam logic [4:0]  FRAME_COUNT  = 5'h18;

   // ==================================================================
   // Command codes
   localparam logic [3:0]  CMD_WRITE_INPUT = 4'h1;
   localparam logic [3:0]  CMD_UPDATE_DAC  = 4'h2;
   localparam logic [3:0]  CMD_WRITE_UPD   = 4'h3;
   localparam logic [3:0]  CMD_MASK_LOAD   = 4'h5;
   localparam logic [3:0]  CMD_SOFT_RESET  = 4'h6;
   localparam logic [3:0]  CMD_REF_SETUP   = 4'h7;

   // ==================================================================
   // Reset values
   localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
   localparam logic [15:0] CODE_MIDSCALE   = 16'h8000;
   localparam logic [3:0]  MASK_RESET      = 4'h0;
   localparam logic        REF_OFF_RESET   = 1'b0;

   // ==================================================================
   // Pin synchroniser slots
   localparam int          PIN_COUNT   = 6;
   localparam int          PIN_SCLK    = 0;
   localparam int          PIN_SYNC    = 1;
   localparam int          PIN_SDIN    = 2;
   localparam int          PIN_STROBE  = 3;
   localparam int          PIN_CLEAR   = 4;
   localparam int          PIN_LEVEL   = 5;

   typedef logic [15:0] code_t;

   typedef struct packed {
      logic [3:0]  command_field;
      logic [3:0]  address_field;
      logic [15:0] data;
   } frame_t;

   typedef enum logic [1:0] {
      ST_WAIT_PIN = 2'b00,
      ST_INIT     = 2'b01,
      ST_RUN      = 2'b10
   } ctrl_state_t;

endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync
   import dac_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 rst_n_i,
   // Pins
   input  wire logic [PIN_COUNT-1:0] pins_i,
   input  wire logic [PIN_COUNT-1:0] reset_val_i,
   // Synchronised levels
   output logic      [PIN_COUNT-1:0] pins_o
);

   logic [PIN_COUNT-1:0] meta_r;

   // ==================================================================
   // One pair of flops per pin; first stage feeds only the second
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_bit
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            // Clear slot starts low so a held clear pin keeps init waiting
            meta_r[i] <= (i != PIN_CLEAR);
            pins_o[i] <= (i != PIN_CLEAR);
         end else begin
            meta_r[i] <= pins_i[i];
            pins_o[i] <= meta_r[i];
         end
      end
   end

   logic unused_reset_val;
   assign unused_reset_val = ^reset_val_i;

endmodule

// File: rtl/dac_ctrl.sv
// Quad DAC serial frame decode, load strobe masking and reset control
`timescale 1ns/1ns

// Operation
// - Mask command copies data bits three..zero
// - Mask bits reset to zero
// - Masked channel ignores strobe falling edge
// - Write input; DAC too if strobe low
// - Update copies input to DAC register
// - Write and update loads both registers
// - Strobe falling edge updates unmasked channels
// - Strobe held low ignores mask bits
// - Clear pin low clears to selected level
// - Cleared value stays after clear release
// - No updates while clear pin low
// - Software reset equals power-on reset
// - Strobe ignored during power-on reset
// - Clear low at power-up delays init
// - Power-up level set by select pin
// - Power-up level held until write
// - Reference command latches data bit zero
// - Command, address, payload field layout
// - 24-bit frame acted on at select rise
// - Write with strobe low updates at rise
// - Deferred update on strobe falling edge
module dac_ctrl
   import dac_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_n_i,
   // Serial link from host
   input  wire logic                sclk_i,
   input  wire logic                sync_n_i,
   input  wire logic                sdin_i,
   // Control pins
   input  wire logic                load_strobe_n_i,
   input  wire logic                clear_n_i,
   input  wire logic                reset_level_select_i,
   // Register contents
   output code_t     [CHANNELS-1:0] input_code_o,
   output code_t     [CHANNELS-1:0] dac_code_o,
   output logic      [3:0]          strobe_mask_o,
   output logic                     ref_disable_o,
   output logic                     ready_o
);

   // ==================================================================
   // Pin synchronisation and edge detection
   logic [PIN_COUNT-1:0] pins_raw;
   logic [PIN_COUNT-1:0] pins_s;
   logic                 sclk_d_r;
   logic                 sync_d_r;
   logic                 strobe_d_r;
   logic                 sclk_fall;
   logic                 sync_rise;
   logic                 strobe_fall;
   logic                 strobe_s;
   logic                 clear_s;

   assign pins_raw[PIN_SCLK]   = sclk_i;
   assign pins_raw[PIN_SYNC]   = sync_n_i;
   assign pins_raw[PIN_SDIN]   = sdin_i;
   assign pins_raw[PIN_STROBE] = load_strobe_n_i;
   assign pins_raw[PIN_CLEAR]  = clear_n_i;
   assign pins_raw[PIN_LEVEL]  = reset_level_select_i;

   pin_sync u_pin_sync (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .pins_i      (pins_raw),
      .reset_val_i (6'h2F),
      .pins_o      (pins_s)
   );

   assign strobe_s = pins_s[PIN_STROBE];
   assign clear_s  = pins_s[PIN_CLEAR];

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_d_r   <= 1'b1;
         sync_d_r   <= 1'b1;
         strobe_d_r <= 1'b1;
      end else begin
         sclk_d_r   <= pins_s[PIN_SCLK];
         sync_d_r   <= pins_s[PIN_SYNC];
         strobe_d_r <= strobe_s;
      end
   end

   assign sclk_fall   = sclk_d_r & ~pins_s[PIN_SCLK];
   assign sync_rise   = ~sync_d_r & pins_s[PIN_SYNC];
   assign strobe_fall = strobe_d_r & ~strobe_s;

   // ==================================================================
   // Serial shift register
   logic [FRAME_BITS-1:0] shift_r;
   logic [4:0]            bit_cnt_r;
   frame_t                frame;
   logic                  frame_go;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_r   <= '0;
         bit_cnt_r <= '0;
      end else if (pins_s[PIN_SYNC]) begin
         bit_cnt_r <= '0;
      end else if (sclk_fall) begin
         shift_r <= {shift_r[FRAME_BITS-2:0], pins_s[PIN_SDIN]};
         if (bit_cnt_r != FRAME_COUNT) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // Short frames are dropped; extra clocks keep only the last 24 bits
   assign frame    = frame_t'(shift_r);
   assign frame_go = sync_rise && (bit_cnt_r == FRAME_COUNT);

   // ==================================================================
   // Power-up and reset sequencing
   ctrl_state_t state_r;
   logic        run_ok;
   logic        frame_act;
   logic        init_load;
   logic        level_r;
   logic        level_sel;
   code_t       reset_code;

   assign run_ok    = (state_r == ST_RUN) && clear_s;
   assign frame_act = frame_go && run_ok;
   assign init_load = (state_r == ST_INIT);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_WAIT_PIN;
      end else begin
         case (state_r)
            ST_WAIT_PIN: begin
               if (clear_s) begin
                  state_r <= ST_INIT;
               end
            end
            ST_INIT: begin
               state_r <= ST_RUN;
            end
            ST_RUN: begin
               if (frame_act && frame.command_field == CMD_SOFT_RESET) begin
                  state_r <= ST_INIT;
               end
            end
            default: begin
               state_r <= ST_WAIT_PIN;
            end
         endcase
      end
   end

   // Select level is caught after reset release, never by the reset itself
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_r <= 1'b0;
      end else if (state_r != ST_RUN) begin
         level_r <= pins_s[PIN_LEVEL];
      end
   end

   // Outside run the live pin counts, so a soft reset sees a new select level
   assign level_sel  = (state_r == ST_RUN) ? level_r : pins_s[PIN_LEVEL];
   assign reset_code = level_sel ? CODE_MIDSCALE : CODE_ZERO_SCALE;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= (state_r == ST_RUN);
      end
   end

   // ==================================================================
   // Strobe mask and reference control
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strobe_mask_o <= MASK_RESET;
      end else if (init_load) begin
         strobe_mask_o <= MASK_RESET;
      end else if (frame_act && frame.command_field == CMD_MASK_LOAD) begin
         strobe_mask_o <= frame.data[3:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_disable_o <= REF_OFF_RESET;
      end else if (init_load) begin
         ref_disable_o <= REF_OFF_RESET;
      end else if (frame_act && frame.command_field == CMD_REF_SETUP) begin
         ref_disable_o <= frame.data[0];
      end
   end

   // ==================================================================
   // Per-channel input and DAC registers
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic sel;
      logic cmd_write;
      logic cmd_update;
      logic cmd_wrupd;
      logic hw_load;

      assign sel        = frame.address_field[ch];
      assign cmd_write  = frame_act && sel && frame.command_field == CMD_WRITE_INPUT;
      assign cmd_update = frame_act && sel && frame.command_field == CMD_UPDATE_DAC;
      assign cmd_wrupd  = frame_act && sel && frame.command_field == CMD_WRITE_UPD;
      // Masked channels ignore the strobe falling edge, as if the pin stayed high
      assign hw_load    = run_ok && strobe_fall && !strobe_mask_o[ch];

      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            input_code_o[ch] <= CODE_ZERO_SCALE;
         end else if (init_load || (state_r == ST_RUN && !clear_s)) begin
            input_code_o[ch] <= reset_code;
         end else if (cmd_write || cmd_wrupd) begin
            input_code_o[ch] <= frame.data;
         end
      end

      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            dac_code_o[ch] <= CODE_ZERO_SCALE;
         end else if (init_load || (state_r == ST_RUN && !clear_s)) begin
            dac_code_o[ch] <= reset_code;
         end else if (cmd_wrupd || (cmd_write && !strobe_s)) begin
            // Strobe held low: write lands in the DAC regardless of mask
            dac_code_o[ch] <= frame.data;
         end else if (cmd_update) begin
            dac_code_o[ch] <= input_code_o[ch];
         end else if (hw_load) begin
            dac_code_o[ch] <= input_code_o[ch];
         end
      end
   end

   // ==================================================================
   // Assertions
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   mask_load_a: assert property (
      frame_act && frame.command_field == CMD_MASK_LOAD
      |=> strobe_mask_o == $past(frame.data[3:0]))
      else $error("Mask not loaded from frame");

   ref_latch_a: assert property (
      frame_act && frame.command_field == CMD_REF_SETUP
      |=> ref_disable_o == $past(frame.data[0]))
      else $error("Reference bit not latched");

   masked_hold_a: assert property (
      strobe_fall && strobe_mask_o[0] && !frame_act && run_ok
      |=> $stable(dac_code_o[0]))
      else $error("Masked channel followed strobe");

   strobe_edge_a: assert property (
      strobe_fall && !strobe_mask_o[1] && !frame_act && run_ok
      |=> dac_code_o[1] == $past(input_code_o[1]))
      else $error("Unmasked channel missed strobe edge");

   write_hold_a: assert property (
      frame_act && frame.command_field == CMD_WRITE_INPUT && frame.address_field[2]
      && strobe_s && !strobe_fall
      |=> input_code_o[2] == $past(frame.data) && $stable(dac_code_o[2]))
      else $error("Write input changed DAC with strobe high");

   write_low_a: assert property (
      frame_act && frame.command_field == CMD_WRITE_INPUT && frame.address_field[3]
      && !strobe_s
      |=> dac_code_o[3] == $past(frame.data))
      else $error("Write with strobe low missed DAC");

   update_cmd_a: assert property (
      frame_act && frame.command_field == CMD_UPDATE_DAC && frame.address_field[0]
      |=> dac_code_o[0] == $past(input_code_o[0]) && $stable(input_code_o[0]))
      else $error("Update command wrong");

   clear_hold_a: assert property (
      (state_r == ST_RUN && !clear_s) [*2]
      |-> dac_code_o[1] == reset_code)
      else $error("DAC updated while clear pin low");

   soft_reset_a: assert property (
      frame_act && frame.command_field == CMD_SOFT_RESET
      |=> ##1 dac_code_o[2] == reset_code && strobe_mask_o == MASK_RESET)
      else $error("Software reset did not restore power-on state");

   wait_pin_a: assert property (
      state_r == ST_WAIT_PIN && !clear_s |=> state_r == ST_WAIT_PIN)
      else $error("Init started with clear pin low");

   cov_deferred_c: cover property (
      frame_act && frame.command_field == CMD_WRITE_INPUT && strobe_s
      ##[1:200] strobe_fall);
   cov_mask_c: cover property (frame_act && frame.command_field == CMD_MASK_LOAD);
   cov_soft_c: cover property (frame_act && frame.command_field == CMD_SOFT_RESET);
   cov_clear_c: cover property (state_r == ST_RUN && !clear_s);

endmodule

// File: bench/host_model.sv
// Host serial master model that sends 24-bit frames to the block
`timescale 1ns/1ns
module host_model
   import dac_ctrl_pkg::*;
(
   // Clock
   input  wire logic clock_i,
   // Serial link
   output logic      sclk_o,
   output logic      sync_n_o,
   output logic      sdin_o
);
   // ==================================================================
   // Idle levels
   initial begin
      sclk_o   = 1'b1;
      sync_n_o = 1'b1;
      sdin_o   = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   // ==================================================================
   // Frame transfer: data moves while clock high, taken on its fall
   task automatic send(input frame_t f);
      logic [FRAME_BITS-1:0] w;
      w = f;
      @(posedge clock_i);
      sync_n_o <= 1'b0;
      for (int i = FRAME_BITS - 1; i >= 0; i--) begin
         sdin_o <= w[i];
         wait_clk(4);
         sclk_o <= 1'b0;
         wait_clk(4);
         sclk_o <= 1'b1;
      end
      wait_clk(4);
      sync_n_o <= 1'b1;
      // Released line shows the inverse, not a stale copy
      sdin_o   <= ~w[0];
      wait_clk(8);
   endtask
endmodule

// File: bench/tb_quad_dac_update_reset_control.sv
// Self-checking bench for the quad DAC update and reset control block
`timescale 1ns/1ns
module tb_quad_dac_update_reset_control
   import dac_ctrl_pkg::*;
;
   logic                 clock_i              = 1'b0;
   logic                 rst_n_i              = 1'b0;
   logic                 load_strobe_n_i      = 1'b1;
   logic                 clear_n_i            = 1'b0;
   logic                 reset_level_select_i = 1'b1;
   logic                 sclk;
   logic                 sync_n;
   logic                 sdin;
   code_t [CHANNELS-1:0] input_code_o;
   code_t [CHANNELS-1:0] dac_code_o;
   logic  [3:0]          strobe_mask_o;
   logic                 ref_disable_o;
   logic                 ready_o;
   code_t                exp_in [CHANNELS];
   code_t                exp_dac [CHANNELS];
   logic  [3:0]          exp_mask;
   logic                 exp_ref;
   frame_t               f;
   code_t                ref_vals [3] = '{16'hFFFF, 16'hFFFE, 16'h0001};
   int                   fail_count = 0;
   int                   compares = 0;
   int                   cycles = 0;

   always #10 clock_i = ~clock_i;

   dac_ctrl i_dut (
      .clock_i              (clock_i),
      .rst_n_i              (rst_n_i),
      .sclk_i               (sclk),
      .sync_n_i             (sync_n),
      .sdin_i               (sdin),
      .load_strobe_n_i      (load_strobe_n_i),
      .clear_n_i            (clear_n_i),
      .reset_level_select_i (reset_level_select_i),
      .input_code_o         (input_code_o),
      .dac_code_o           (dac_code_o),
      .strobe_mask_o        (strobe_mask_o),
      .ref_disable_o        (ref_disable_o),
      .ready_o              (ready_o)
   );

   host_model i_host (
      .clock_i  (clock_i),
      .sclk_o   (sclk),
      .sync_n_o (sync_n),
      .sdin_o   (sdin)
   );

   // ==================================================================
   // Checking and reporting
   task automatic report_and_stop();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_state();
      for (int c = 0; c < CHANNELS; c++) begin
         chk($sformatf("input_code %0d", c), exp_in[c], input_code_o[c]);
         chk($sformatf("dac_code %0d", c), exp_dac[c], dac_code_o[c]);
      end
      chk("strobe_mask", {12'h000, exp_mask}, {12'h000, strobe_mask_o});
      chk("ref_disable", {15'h0000, exp_ref}, {15'h0000, ref_disable_o});
   endtask

   task automatic wait_ready();
      for (int i = 0; i < 100 && ready_o !== 1'b1; i++) @(posedge clock_i);
      chk("ready", 16'h0001, {15'h0000, ready_o});
   endtask

   task automatic set_all(input code_t v);
      for (int c = 0; c < CHANNELS; c++) begin
         exp_in[c]  = v;
         exp_dac[c] = v;
      end
   endtask

   // ==================================================================
   // Operations with their expected effect
   task automatic op(input logic [3:0] cmd, input logic [3:0] adr, input code_t d);
      f = '{cmd, adr, d};
      i_host.send(f);
      for (int c = 0; c < CHANNELS; c++) begin
         if (adr[c] && cmd == CMD_UPDATE_DAC) exp_dac[c] = exp_in[c];
         if (adr[c] && (cmd == CMD_WRITE_INPUT || cmd == CMD_WRITE_UPD)) exp_in[c] = d;
         if (adr[c] && (cmd == CMD_WRITE_UPD || (cmd == CMD_WRITE_INPUT && !load_strobe_n_i)))
            exp_dac[c] = d;
      end
      if (cmd == CMD_MASK_LOAD) exp_mask = d[3:0];
      if (cmd == CMD_REF_SETUP) exp_ref = d[0];
   endtask

   task automatic strobe_pulse();
      @(posedge clock_i);
      load_strobe_n_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      load_strobe_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      for (int c = 0; c < CHANNELS; c++) begin
         if (!exp_mask[c]) exp_dac[c] = exp_in[c];
      end
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      set_all(CODE_MIDSCALE);
      exp_mask = MASK_RESET;
      exp_ref  = REF_OFF_RESET;
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (30) @(posedge clock_i);
      chk("ready", 16'h0000, {15'h0000, ready_o});
      clear_n_i <= 1'b1;
      wait_ready();
      check_state();
      op(CMD_WRITE_INPUT, 4'h1, 16'hABCD);
      check_state();
      strobe_pulse();
      check_state();
      // Address and upper payload bits must not reach the mask
      op(CMD_MASK_LOAD, 4'hF, 16'hFFF5);
      check_state();
      op(CMD_WRITE_INPUT, 4'hF, 16'h1234);
      strobe_pulse();
      check_state();
      @(posedge clock_i);
      load_strobe_n_i <= 1'b0;
      op(CMD_WRITE_INPUT, 4'hD, 16'h5555);
      check_state();
      load_strobe_n_i <= 1'b1;
      op(CMD_WRITE_INPUT, 4'h3, 16'h7777);
      check_state();
      op(CMD_UPDATE_DAC, 4'h3, 16'h0000);
      check_state();
      op(CMD_WRITE_UPD, 4'h8, 16'hBEEF);
      check_state();
      for (int k = 0; k < 3; k++) begin
         op(CMD_REF_SETUP, 4'hF, ref_vals[k]);
         check_state();
      end
      // Clear held far longer than the block needs to see it
      @(posedge clock_i);
      clear_n_i <= 1'b0;
      repeat (10) @(posedge clock_i);
      f = '{CMD_WRITE_UPD, 4'hF, 16'h1111};
      i_host.send(f);
      set_all(CODE_MIDSCALE);
      check_state();
      clear_n_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      check_state();
      @(posedge clock_i);
      reset_level_select_i <= 1'b0;
      op(CMD_SOFT_RESET, 4'h0, 16'h0000);
      set_all(CODE_ZERO_SCALE);
      exp_mask = MASK_RESET;
      exp_ref  = REF_OFF_RESET;
      wait_ready();
      check_state();
      report_and_stop();
   end
endmodule
